// ---- hdl/slot_control.sv ----
// Notes on behaviour
// - Up to three 64-bit slots sit on the primary bus and can each run at the fast rate.
// - The two bridge halves act as one, voting on CPU requests and dropping a faulty CPU.
// - The speed-enable line is one wired-OR line for all slots, high meaning all can go fast.
// - The speed select comes from the speed-enable line, goes to both bridge halves and clock, and can be forced.
// - The 64-bit request line is held low for the whole bus reset.
// - Each slot select comes from its own address line so a configuration cycle hits one device.
// - Slot resets are per slot, slots 1 and 2 from the C half and slot 3 from the D half.
// - The three slot interrupts of a board go to both bridge halves on it.
// - All six interrupts of both boards map to dedicated north-bridge inputs.
// - All logic runs on one clock and the slot clocks are derived in phase from it.
// - Each slot clock runs at the full derived rate or half of it per the speed select.
`timescale 1ns/1ps
`default_nettype none

module slot_control (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic bus_reset_req_i,
  input wire logic force_66_i,
  input wire logic force_33_i,
  input wire logic m66en_i,
  input wire logic board_side_i,
  input wire logic [slot_ctl_pkg::NUM_SLOTS-1:0] slot_int_n_i,
  input wire logic [slot_ctl_pkg::NUM_SLOTS-1:0] partner_int_n_i,
  input wire logic [slot_ctl_pkg::NUM_C_SLOTS-1:0] c_slot_reset_i,
  input wire logic d_slot_reset_i,
  input wire logic [slot_ctl_pkg::NUM_CPU-1:0] cpu_cfg_valid_i,
  input wire logic [slot_ctl_pkg::DEV_WIDTH-1:0] cpu_a_cfg_dev_i,
  input wire logic [slot_ctl_pkg::DEV_WIDTH-1:0] cpu_b_cfg_dev_i,
  input wire logic [slot_ctl_pkg::NUM_CPU-1:0] cpu_err_i,
  output logic clock_sel_66_o,
  output logic [slot_ctl_pkg::NUM_SLOTS-1:0] slot_rst_n_o,
  output logic req64_n_o,
  output logic req64_oe_o,
  output logic [slot_ctl_pkg::NUM_SLOTS-1:0] slot_clk_o,
  output logic cfg_valid_o,
  output logic [slot_ctl_pkg::AD_WIDTH-1:0] cfg_ad_o,
  output logic [slot_ctl_pkg::NUM_CPU-1:0] cpu_active_o,
  output logic vote_mismatch_o,
  output logic [slot_ctl_pkg::NUM_SLOTS-1:0] asic_c_int_o,
  output logic [slot_ctl_pkg::NUM_SLOTS-1:0] asic_d_int_o,
  output logic [slot_ctl_pkg::NUM_SYS_INT-1:0] nb_int_o
);

  // Constants and state codes shared with the checker
  import slot_ctl_pkg::*;

  // Two straps plus the local and partner interrupt groups
  localparam int SYNC_W = 2 + 2 * NUM_SLOTS;

  // Address word with only the select line of one device set
  function automatic logic [AD_WIDTH-1:0] dev_to_ad(input logic [DEV_WIDTH-1:0] dev);
    logic [AD_WIDTH-1:0] ad;
    ad = '0;
    ad[IDSEL_BASE_BIT + int'(dev)] = 1'b1;
    return ad;
  endfunction : dev_to_ad

  // Both CPUs set in one per-CPU mask
  function automatic logic both_set(input logic [NUM_CPU-1:0] mask);
    return &mask;
  endfunction : both_set

  typedef struct packed {
    // Bus reset sequencing and what it latches
    bus_state_t st;
    logic [HOLD_CNT_WIDTH-1:0] hold_cnt;
    logic speed66;
    logic side;
    // Pins towards the slots
    logic [NUM_SLOTS-1:0] slot_rst_n;
    logic req64_n;
    logic req64_oe;
    logic [NUM_SLOTS-1:0] slot_clk;
    // Configuration voter
    logic cfg_valid;
    logic [AD_WIDTH-1:0] cfg_ad;
    logic [NUM_CPU-1:0] active;
    logic mismatch;
    // Interrupt routing
    logic [NUM_SLOTS-1:0] int_c;
    logic [NUM_SLOTS-1:0] int_d;
    logic [NUM_SYS_INT-1:0] nb_int;
  } ctl_state_t;

  ctl_state_t q, d;

  // Raw, reset and synchronised pin words
  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_rst;
  logic [SYNC_W-1:0] pins;
  logic m66en_s;
  logic side_s;
  logic [NUM_SLOTS-1:0] slot_int_n_s;
  logic [NUM_SLOTS-1:0] partner_int_n_s;
  // Slot clock enable, slot reset requests and voter decode
  logic rate_en;
  logic [NUM_SLOTS-1:0] slot_req_rst;
  logic [DEV_WIDTH-1:0] vote_dev;
  logic vote_go;

  // Enable pulses for the two slot clock rates
  rate_if rate ();

  rate_div u_rate_div (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .rate(rate.src)
  );

  // All off-board levels pass the same three-stage synchroniser
  assign pins_raw = {m66en_i, board_side_i, slot_int_n_i, partner_int_n_i};
  assign pins_rst = {1'b0, 1'b0, RST_INT_N, RST_INT_N};

  pin_sync #(
    .WIDTH(SYNC_W)
  ) u_pin_sync (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .rst_val_i(pins_rst),
    .pin_i(pins_raw),
    .level_o(pins)
  );

  // Split the synchronised word back into its parts
  assign m66en_s = pins[SYNC_W-1];
  assign side_s = pins[SYNC_W-2];
  assign slot_int_n_s = pins[2*NUM_SLOTS-1:NUM_SLOTS];
  assign partner_int_n_s = pins[NUM_SLOTS-1:0];

  // Slot clock enable picked from the held speed select
  // The select only moves during bus reset, so run never sees a glitch
  assign rate_en = q.speed66 ? rate.en_full : rate.en_half;

  // Per-slot reset requests from the two bridge halves
  assign slot_req_rst = {d_slot_reset_i, c_slot_reset_i};

  // Vote on configuration requests from the two CPUs
  always_comb begin
    vote_go = 1'b0;
    vote_dev = cpu_a_cfg_dev_i;
    if (both_set(q.active)) begin
      // Both in service: issue only when they agree
      if (both_set(cpu_cfg_valid_i) && cpu_a_cfg_dev_i == cpu_b_cfg_dev_i) begin
        vote_go = 1'b1;
      end
    end else if (q.active == 2'h1) begin
      // One CPU left: follow it alone
      vote_go = cpu_cfg_valid_i[0];
    end else if (q.active == 2'h2) begin
      vote_go = cpu_cfg_valid_i[1];
      vote_dev = cpu_b_cfg_dev_i;
    end
  end

  // Main sequencer, voter and routing
  always_comb begin
    d = q;
    d.cfg_valid = 1'b0;

    case (q.st)
      ST_RESET: begin
        // Every slot reset and the 64-bit request drop together
        d.slot_rst_n = '0;
        d.req64_n = 1'b0;
        d.req64_oe = 1'b1;
        // Forcing wins over the wired-OR line; fast only when all agree
        if (force_66_i) begin
          d.speed66 = 1'b1;
        end else if (force_33_i) begin
          d.speed66 = 1'b0;
        end else begin
          d.speed66 = m66en_s;
        end
        d.side = side_s;
        // Hold for the minimum time, then for as long as the request stays
        if (q.hold_cnt != '0) begin
          d.hold_cnt = q.hold_cnt - 8'h01;
        end else if (!bus_reset_req_i) begin
          d.st = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        // Release resets while the 64-bit request is still low, so every
        // card released here sees it low at its reset edge; it goes high one cycle later
        d.slot_rst_n = ~slot_req_rst;
        d.req64_n = 1'b0;
        d.st = ST_RUN;
      end
      ST_RUN: begin
        // Drive the request high for a cycle before letting the line go
        d.req64_n = 1'b1;
        if (q.req64_n) begin
          d.req64_oe = 1'b0;
        end
        // Individual slot resets apply in release and while running
        d.slot_rst_n = ~slot_req_rst;
        if (bus_reset_req_i) begin
          d.st = ST_RESET;
          d.hold_cnt = RST_HOLD_CYC;
        end
      end
      // Unused code falls back to a full bus reset
      default: begin
        d.st = ST_RESET;
        d.hold_cnt = RST_HOLD_CYC;
      end
    endcase

    // Slot clocks toggle together so all stay in phase
    // Toggling on the enable keeps each clock a clean square wave
    if (rate_en) begin
      d.slot_clk = ~q.slot_clk;
    end

    // A disagreeing CPU that flags its own fault is dropped, CPU A if both flag; without a
    // self-flag neither can be blamed, so the split is only reported
    d.mismatch = 1'b0;
    if (both_set(q.active) && both_set(cpu_cfg_valid_i) &&
        cpu_a_cfg_dev_i != cpu_b_cfg_dev_i) begin
      if (cpu_err_i[0]) begin
        d.active = 2'h2;
      end else if (cpu_err_i[1]) begin
        d.active = 2'h1;
      end else begin
        d.mismatch = 1'b1;
      end
    end

    // Configuration only in run, only to a device that has a select line
    // Device numbers past the top address line have no select and are dropped
    if (vote_go && q.st == ST_RUN && int'(vote_dev) < AD_WIDTH - IDSEL_BASE_BIT) begin
      d.cfg_valid = 1'b1;
      d.cfg_ad = dev_to_ad(vote_dev);
    end

    // Slot interrupts to both bridge halves, active low
    // Registered so both halves see a change in the same cycle
    d.int_c = slot_int_n_s;
    d.int_d = slot_int_n_s;

    // Side 0 board owns the low three north-bridge inputs
    // Side 1 swaps halves so both boards agree on the system order
    if (q.side) begin
      d.nb_int = {slot_int_n_s, partner_int_n_s};
    end else begin
      d.nb_int = {partner_int_n_s, slot_int_n_s};
    end
  end

  // Power-up starts a full bus reset
  // Fields not named below start at zero
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      q <= '0;
      q.st <= ST_RESET;
      q.hold_cnt <= RST_HOLD_CYC;
      q.speed66 <= RST_SPEED66;
      q.slot_rst_n <= RST_SLOT_RST_N;
      q.req64_oe <= 1'b1;
      q.active <= RST_CPU_ACTIVE;
      q.int_c <= RST_INT_N;
      q.int_d <= RST_INT_N;
      q.nb_int <= {RST_INT_N, RST_INT_N};
    end else begin
      q <= d;
    end
  end

  // Speed select and slot resets, straight from the state register
  assign clock_sel_66_o = q.speed66;
  assign slot_rst_n_o = q.slot_rst_n;

  // 64-bit request pin and its enable
  assign req64_n_o = q.req64_n;
  assign req64_oe_o = q.req64_oe;

  // Slot clocks and configuration select
  assign slot_clk_o = q.slot_clk;
  assign cfg_valid_o = q.cfg_valid;
  assign cfg_ad_o = q.cfg_ad;

  // Voter status
  assign cpu_active_o = q.active;
  assign vote_mismatch_o = q.mismatch;

  // Interrupt copies
  assign asic_c_int_o = q.int_c;
  assign asic_d_int_o = q.int_d;
  assign nb_int_o = q.nb_int;

endmodule : slot_control

`default_nettype wire

// ---- hdl/slot_ctl_pkg.sv ----
package slot_ctl_pkg;

  // Slot population and address-line select
  localparam int NUM_SLOTS = 3;
  localparam int NUM_C_SLOTS = 2;
  localparam int IDSEL_BASE_BIT = 16;
  localparam int AD_WIDTH = 32;
  localparam int DEV_WIDTH = 4;
  localparam int NUM_SYS_INT = 6;
  localparam int NUM_CPU = 2;

  // Core clock period and reset hold time
  localparam int CLK_PERIOD_PS = 8000;
  localparam int RST_HOLD_NS = 1000;
  localparam int RST_HOLD_CYC_INT = (RST_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HOLD_CNT_WIDTH = 8;
  localparam logic [HOLD_CNT_WIDTH-1:0] RST_HOLD_CYC = RST_HOLD_CYC_INT[HOLD_CNT_WIDTH-1:0];

  // Full-rate slot clock half period, longest time so it rounds down, but never below one core cycle
  localparam int FULL_HALF_PERIOD_PS = 7500;
  localparam int FULL_DIV_INT = (FULL_HALF_PERIOD_PS >= CLK_PERIOD_PS) ?
                                (FULL_HALF_PERIOD_PS / CLK_PERIOD_PS) : 1;
  localparam int DIV_CNT_WIDTH = 4;
  localparam logic [DIV_CNT_WIDTH-1:0] FULL_DIV_CYC = FULL_DIV_INT[DIV_CNT_WIDTH-1:0];

  // Reset values
  localparam logic RST_SPEED66 = 1'b0;
  localparam logic [NUM_CPU-1:0] RST_CPU_ACTIVE = 2'h3;
  localparam logic [NUM_SLOTS-1:0] RST_SLOT_RST_N = 3'h0;
  localparam logic [NUM_SLOTS-1:0] RST_INT_N = 3'h7;

  // Bus reset sequencer
  typedef enum logic [1:0] {
    ST_RUN     = 2'b00,
    ST_RESET   = 2'b01,
    ST_RELEASE = 2'b10
  } bus_state_t;

endpackage : slot_ctl_pkg

// ---- hdl/rate_if.sv ----
`timescale 1ns/1ps
`default_nettype none

// Enable pulses for the two slot clock rates
interface rate_if;
  logic en_full;
  logic en_half;
  modport src (output en_full, output en_half);
  modport dst (input en_full, input en_half);
endinterface : rate_if

`default_nettype wire

// ---- hdl/rate_div.sv ----
`timescale 1ns/1ps
`default_nettype none

module rate_div
  import slot_ctl_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  rate_if.src rate
);

  typedef struct packed {
    logic [DIV_CNT_WIDTH-1:0] cnt;
    logic phase;
    logic en_full;
    logic en_half;
  } div_state_t;

  div_state_t q, d;

  // Half rate is every other full-rate pulse, so both stay phase aligned
  always_comb begin
    d = q;
    d.en_full = 1'b0;
    d.en_half = 1'b0;
    if (q.cnt == FULL_DIV_CYC - 4'h1) begin
      d.cnt = '0;
      d.en_full = 1'b1;
      d.phase = ~q.phase;
      d.en_half = q.phase;
    end else begin
      d.cnt = q.cnt + 4'h1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rate.en_full = q.en_full;
  assign rate.en_half = q.en_half;

endmodule : rate_div

`default_nettype wire

// ---- hdl/pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] rst_val_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } sync_state_t;

  sync_state_t q, d;

  // Only s2 reads s1; a bit moves once s2 and s3 agree
  always_comb begin
    d = q;
    d.s1 = pin_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.level[i] = q.s3[i];
      end
    end
  end

  // Reset level is a fixed per-instance constant
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      q <= {rst_val_i, rst_val_i, rst_val_i, rst_val_i};
    end else begin
      q <= d;
    end
  end

  assign level_o = q.level;

endmodule : pin_sync

`default_nettype wire

// ---- tb/slot_cards.sv ----
`timescale 1ns/1ps
`default_nettype none
module slot_cards (
  input wire logic [2:0] slot_rst_n_i,
  input wire logic req64_n_i,
  input wire logic req64_oe_i,
  input wire logic [2:0] slow_i,
  input wire logic [2:0] irq_i,
  output logic m66en_o,
  output logic [2:0] int_n_o,
  output var logic [2:0] wide_o
);
  // Pulled up, a slow card grounds it
  assign m66en_o = ~|slow_i;
  // Open-drain interrupts with pull-ups
  assign int_n_o = ~irq_i;
  // Width caught at own reset release; undriven line reads high
  for (genvar i = 0; i < 3; i++) begin : g_card
    always @(posedge slot_rst_n_i[i]) begin
      wide_o[i] <= req64_oe_i && !req64_n_i;
    end
  end
endmodule : slot_cards
`default_nettype wire

// ---- tb/slot_control_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module slot_control_assertions
  import slot_ctl_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic force_66_i,
  input wire logic force_33_i,
  input wire logic [NUM_SLOTS-1:0] slot_int_n_i,
  input wire logic [NUM_C_SLOTS-1:0] c_slot_reset_i,
  input wire logic d_slot_reset_i,
  input wire logic [NUM_CPU-1:0] cpu_cfg_valid_i,
  input wire logic [DEV_WIDTH-1:0] cpu_a_cfg_dev_i,
  input wire logic [DEV_WIDTH-1:0] cpu_b_cfg_dev_i,
  input wire logic clock_sel_66_o,
  input wire logic [NUM_SLOTS-1:0] slot_rst_n_o,
  input wire logic req64_n_o,
  input wire logic req64_oe_o,
  input wire logic [NUM_SLOTS-1:0] slot_clk_o,
  input wire logic cfg_valid_o,
  input wire logic [AD_WIDTH-1:0] cfg_ad_o,
  input wire logic [NUM_CPU-1:0] cpu_active_o,
  input wire logic [NUM_SLOTS-1:0] asic_c_int_o,
  input wire logic [NUM_SLOTS-1:0] asic_d_int_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  property p_oe; !req64_n_o |-> req64_oe_o; endproperty
  a_oe: assert property (p_oe) else $error("req64 low undriven");
  property p_fall; $fell(req64_n_o) |-> slot_rst_n_o == 3'h0; endproperty
  a_fall: assert property (p_fall) else $error("req64 low outside reset");
  property p_rise; $rose(req64_n_o) |-> $past(slot_rst_n_o, 2) == 3'h0; endproperty
  a_rise: assert property (p_rise) else $error("req64 left before reset end");
  // Only the run state may be assumed frozen
  property p_hold; req64_n_o && $past(req64_n_o) |-> $stable(clock_sel_66_o); endproperty
  a_hold: assert property (p_hold) else $error("speed changed in run");
  property p_srst;
    req64_n_o && $past(req64_n_o) && $past(req64_n_o, 2)
      |-> slot_rst_n_o == ~$past({d_slot_reset_i, c_slot_reset_i});
  endproperty
  a_srst: assert property (p_srst) else $error("slot reset wrong");
  property p_force;
    !req64_n_o && !$past(req64_n_o) && $past(force_66_i || force_33_i)
      |-> clock_sel_66_o == $past(force_66_i);
  endproperty
  a_force: assert property (p_force) else $error("force ignored");
  property p_ad;
    cfg_valid_o && $past(cpu_active_o) == 2'h3
      |-> cfg_ad_o == 32'h1 << (IDSEL_BASE_BIT + $past(cpu_a_cfg_dev_i));
  endproperty
  a_ad: assert property (p_ad) else $error("select line wrong");
  property p_vote;
    $past(cpu_cfg_valid_i) == 2'h3 && $past(cpu_active_o) == 2'h3
      && $past(cpu_a_cfg_dev_i) != $past(cpu_b_cfg_dev_i) |-> !cfg_valid_o;
  endproperty
  a_vote: assert property (p_vote) else $error("mismatch issued");
  property p_int;
    $stable(slot_int_n_i) [*7] |-> asic_c_int_o == slot_int_n_i && asic_d_int_o == slot_int_n_i;
  endproperty
  a_int: assert property (p_int) else $error("interrupt copy wrong");
  property p_full;
    $past(clock_sel_66_o, 2) && $past(clock_sel_66_o)
      |-> slot_clk_o == ~$past(slot_clk_o) && (slot_clk_o == 3'h0 || slot_clk_o == 3'h7);
  endproperty
  a_full: assert property (p_full) else $error("fast clock wrong");
  c_cfg: cover property (cfg_valid_o);
  c_drop: cover property ($fell(cpu_active_o[0]));
  c_fast: cover property ($rose(clock_sel_66_o));
endmodule : slot_control_assertions
bind slot_control slot_control_assertions i_chk (.core_clk_i, .reset_i, .force_66_i,
  .force_33_i, .slot_int_n_i, .c_slot_reset_i, .d_slot_reset_i, .cpu_cfg_valid_i,
  .cpu_a_cfg_dev_i, .cpu_b_cfg_dev_i, .clock_sel_66_o, .slot_rst_n_o, .req64_n_o,
  .req64_oe_o, .slot_clk_o, .cfg_valid_o, .cfg_ad_o, .cpu_active_o, .asic_c_int_o,
  .asic_d_int_o);
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import slot_ctl_pkg::*;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic bus_reset_req_i = 1'b0, force_66_i = 1'b0, force_33_i = 1'b0, board_side_i = 1'b0;
  logic d_slot_reset_i = 1'b0;
  logic [2:0] slow = 3'h0, irq = 3'h0, partner_int_n_i = 3'h7;
  logic [1:0] c_slot_reset_i = 2'h0, cpu_cfg_valid_i = 2'h0, cpu_err_i = 2'h0;
  logic [3:0] cpu_a_cfg_dev_i = 4'h0, cpu_b_cfg_dev_i = 4'h0;
  wire logic m66en_i, clock_sel_66_o, req64_n_o, req64_oe_o, cfg_valid_o, vote_mismatch_o;
  wire logic [2:0] slot_int_n_i, slot_rst_n_o, slot_clk_o, asic_c_int_o, asic_d_int_o, wide;
  wire logic [1:0] cpu_active_o;
  wire logic [31:0] cfg_ad_o;
  wire logic [5:0] nb_int_o;
  int failures = 0, num_checks = 0;
  always #4 core_clk_i = ~core_clk_i;
  slot_control i_dut (.core_clk_i, .reset_i, .bus_reset_req_i, .force_66_i, .force_33_i,
    .m66en_i, .board_side_i, .slot_int_n_i, .partner_int_n_i, .c_slot_reset_i,
    .d_slot_reset_i, .cpu_cfg_valid_i, .cpu_a_cfg_dev_i, .cpu_b_cfg_dev_i, .cpu_err_i,
    .clock_sel_66_o, .slot_rst_n_o, .req64_n_o, .req64_oe_o, .slot_clk_o, .cfg_valid_o,
    .cfg_ad_o, .cpu_active_o, .vote_mismatch_o, .asic_c_int_o, .asic_d_int_o, .nb_int_o);
  slot_cards i_cards (.slot_rst_n_i(slot_rst_n_o), .req64_n_i(req64_n_o),
    .req64_oe_i(req64_oe_o), .slow_i(slow), .irq_i(irq), .m66en_o(m66en_i),
    .int_n_o(slot_int_n_i), .wide_o(wide));
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic give_verdict();
    if (failures == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  // Bounded wait for run entry, ends off the edge so outputs are settled
  task automatic wait_run(output int n);
    for (n = 0; n < 400 && req64_n_o !== 1'b1; n++) @(posedge core_clk_i);
    repeat (2) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask : wait_run
  task automatic bus_reset();
    int n;
    @(posedge core_clk_i);
    bus_reset_req_i <= 1'b1;
    @(posedge core_clk_i);
    bus_reset_req_i <= 1'b0;
    @(posedge core_clk_i);
    // Let the request line fall first, else run is seen before reset
    @(negedge core_clk_i);
    wait_run(n);
  endtask : bus_reset
  task automatic t_power();
    int n;
    @(negedge core_clk_i);
    chk("req64_n", 0, req64_n_o);
    chk("slot_rst_n", 0, slot_rst_n_o);
    wait_run(n);
    chk("hold", 1, n >= RST_HOLD_CYC);
    chk("req64_oe", 0, req64_oe_o);
    chk("width", 3'h7, wide);
  endtask : t_power
  // Bits: slow card, force fast, force slow, expected select
  task automatic t_speed();
    logic [3:0] tab [5] = '{4'h1, 4'h8, 4'hd, 4'h2, 4'h7};
    logic [2:0] pv;
    int tg;
    foreach (tab[i]) begin
      @(posedge core_clk_i);
      slow <= {1'b0, tab[i][3], 1'b0};
      force_66_i <= tab[i][2];
      force_33_i <= tab[i][1];
      bus_reset();
      chk("clock_sel", tab[i][0], clock_sel_66_o);
      pv = slot_clk_o;
      tg = 0;
      repeat (16) begin
        @(negedge core_clk_i);
        tg += int'(slot_clk_o != pv);
        pv = slot_clk_o;
      end
      chk("toggles", tab[i][0] ? 16 : 8, tg);
    end
    // Sampling only in reset keeps the speed select steady in run
    @(posedge core_clk_i);
    slow <= 3'h7;
    force_66_i <= 1'b0;
    repeat (10) @(negedge core_clk_i);
    chk("clock_sel", 1, clock_sel_66_o);
  endtask : t_speed
  task automatic cfg(logic [1:0] v, logic [3:0] a, logic [3:0] b, logic [1:0] e);
    @(posedge core_clk_i);
    cpu_cfg_valid_i <= v;
    cpu_a_cfg_dev_i <= a;
    cpu_b_cfg_dev_i <= b;
    cpu_err_i <= e;
    @(posedge core_clk_i);
    cpu_cfg_valid_i <= 2'h0;
    cpu_err_i <= 2'h0;
    @(negedge core_clk_i);
  endtask : cfg
  task automatic t_cfg();
    for (int d = 0; d < 3; d++) begin
      cfg(2'h3, d[3:0], d[3:0], 2'h0);
      chk("cfg_ad", 32'h1 << (IDSEL_BASE_BIT + d), cfg_ad_o);
    end
    cfg(2'h3, 4'h1, 4'h2, 2'h0);
    chk("mismatch", 1, vote_mismatch_o);
    cfg(2'h3, 4'h1, 4'h2, 2'h1);
    chk("cpu_active", 2'h2, cpu_active_o);
    cfg(2'h2, 4'h0, 4'h2, 2'h0);
    chk("cfg_valid", 1, cfg_valid_o);
    chk("cfg_ad", 32'h4_0000, cfg_ad_o);
  endtask : t_cfg
  task automatic t_int();
    @(posedge core_clk_i);
    irq <= 3'h5;
    partner_int_n_i <= 3'h6;
    repeat (8) @(negedge core_clk_i);
    chk("asic_c", 3'h2, asic_c_int_o);
    chk("asic_d", 3'h2, asic_d_int_o);
    chk("nb_int", 6'h32, nb_int_o);
    @(posedge core_clk_i);
    board_side_i <= 1'b1;
    bus_reset();
    chk("nb_int", 6'h16, nb_int_o);
  endtask : t_int
  task automatic t_slot_rst();
    @(posedge core_clk_i);
    c_slot_reset_i <= 2'h1;
    d_slot_reset_i <= 1'b1;
    repeat (2) @(negedge core_clk_i);
    chk("slot_rst_n", 3'h2, slot_rst_n_o);
    @(posedge core_clk_i);
    c_slot_reset_i <= 2'h0;
    d_slot_reset_i <= 1'b0;
    repeat (2) @(negedge core_clk_i);
    chk("width", 3'h2, wide);
  endtask : t_slot_rst
  initial begin
    repeat (5) @(posedge core_clk_i);
    reset_i <= 1'b0;
    t_power();
    t_speed();
    t_cfg();
    t_int();
    t_slot_rst();
    give_verdict();
  end
  // About seven bus resets of some 130 cycles each
  initial begin
    repeat (20000) @(posedge core_clk_i);
    failures++;
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
